// ---- logic/cpwm_top.sv ----
// complementary pwm timer top: wishbone registers, counter pair, triggers
module cpwm_top #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // count sources
  input wire logic fast_osc_clock_i,
  input wire logic fast_osc_divided_clock_i,
  input wire logic ext_count_clock_pin_i,
  // pwm pins, bit k is phase k+1
  output logic [2:0] phase_normal_o,
  output logic [2:0] phase_counter_o,
  // converter start and event requests
  output logic adc_trigger_o,
  output logic compare_req_o,
  output logic underflow_req_o
);
  // the register map and the pin ports are laid out for the package sizes only
  if (CNT_W != cpwm_pkg::CNT_W) begin : g_bad_cnt_w
    $error("cpwm_top: counter width must match package width");
  end
  if (cpwm_pkg::PHASES != 3) begin : g_bad_phases
    $error("cpwm_top: the pin ports carry exactly three phases");
  end

  logic [2:0] start_r, start_nxt;
  logic [4:0] ch0_r, ch0_nxt;
  logic [4:0] ch1_r, ch1_nxt;
  logic [1:0] func_r, func_nxt;
  logic [cpwm_pkg::ADC_W-1:0] adc_sel_r, adc_sel_nxt;
  logic [CNT_W-1:0] cnt_a_r, cnt_a_nxt;
  logic [CNT_W-1:0] cnt_b_r, cnt_b_nxt;
  logic [CNT_W-1:0] period_r, period_nxt;
  logic [CNT_W-1:0] period_lat_r, period_lat_nxt;
  logic [CNT_W-1:0] duty_r [cpwm_pkg::PHASES];
  logic [CNT_W-1:0] duty_nxt [cpwm_pkg::PHASES];
  logic down_r, down_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic adc_r, adc_nxt;
  logic cmp_req_r, cmp_req_nxt;
  logic unf_req_r, unf_req_nxt;

  logic running, tick, req, wr, wlo, whi;
  logic turn_down, turn_up, cnt_a_wr, cnt_b_wr;
  logic [cpwm_pkg::ADC_W-1:0] match;

  // a request is taken while ack is low; a write commits at the ack edge,
  // where the master still holds address, lanes and data
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign wlo = wb_sel_i[0];
  assign whi = wb_sel_i[1];

  assign running = start_r[cpwm_pkg::RUN0_BIT] & start_r[cpwm_pkg::RUN1_BIT];

  // channel 1 field is kept but channel 0 drives the pair
  cpwm_clk_src u_src (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_sel_i(ch0_r[cpwm_pkg::SRC_LSB +: cpwm_pkg::SRC_W]),
    .edge_sel_i(ch0_r[cpwm_pkg::EDGE_LSB +: cpwm_pkg::EDGE_W]),
    .fast_osc_clock_i(fast_osc_clock_i),
    .fast_osc_divided_clock_i(fast_osc_divided_clock_i),
    .ext_count_clock_pin_i(ext_count_clock_pin_i),
    .tick_o(tick)
  );

  // match on the tick where values are equal
  assign match[cpwm_pkg::ADC_A_PERIOD] = cnt_a_r == period_lat_r;
  assign match[cpwm_pkg::ADC_A_DUTY1] = cnt_a_r == duty_r[0];
  assign match[cpwm_pkg::ADC_B_DUTY2] = cnt_b_r == duty_r[1];
  assign match[cpwm_pkg::ADC_B_DUTY3] = cnt_b_r == duty_r[2];

  // merge a write with the byte lanes, keeping unselected bytes
  function automatic logic [15:0] merge16(input logic [15:0] old_v);
    merge16 = {whi ? wb_dat_i[15:8] : old_v[15:8], wlo ? wb_dat_i[7:0] : old_v[7:0]};
  endfunction

  always_comb begin
    start_nxt = start_r;
    ch0_nxt = ch0_r;
    ch1_nxt = ch1_r;
    func_nxt = func_r;
    adc_sel_nxt = adc_sel_r;
    period_nxt = period_r;
    duty_nxt = duty_r;
    if (wr && wlo) begin
      unique case (wb_adr_i)
        cpwm_pkg::ADR_START: begin
          start_nxt[cpwm_pkg::MSTOP_BIT] = wb_dat_i[cpwm_pkg::MSTOP_BIT];
          // zero stops only with manual stop enable
          if (wb_dat_i[cpwm_pkg::RUN0_BIT] || start_r[cpwm_pkg::MSTOP_BIT]) begin
            start_nxt[cpwm_pkg::RUN0_BIT] = wb_dat_i[cpwm_pkg::RUN0_BIT];
          end
          if (wb_dat_i[cpwm_pkg::RUN1_BIT] || start_r[cpwm_pkg::MSTOP_BIT]) begin
            start_nxt[cpwm_pkg::RUN1_BIT] = wb_dat_i[cpwm_pkg::RUN1_BIT];
          end
        end
        cpwm_pkg::ADR_CH0_CTRL: ch0_nxt = wb_dat_i[4:0];
        cpwm_pkg::ADR_CH1_CTRL: ch1_nxt = wb_dat_i[4:0];
        cpwm_pkg::ADR_FUNC: func_nxt = wb_dat_i[1:0];
        cpwm_pkg::ADR_ADC_SEL: adc_sel_nxt = wb_dat_i[cpwm_pkg::ADC_W-1:0];
        default: begin
        end
      endcase
    end
    if (wr) begin
      unique case (wb_adr_i)
        cpwm_pkg::ADR_PERIOD: period_nxt = merge16(period_r);
        cpwm_pkg::ADR_DUTY1: duty_nxt[0] = merge16(duty_r[0]);
        cpwm_pkg::ADR_DUTY2: duty_nxt[1] = merge16(duty_r[1]);
        cpwm_pkg::ADR_DUTY3: duty_nxt[2] = merge16(duty_r[2]);
        default: begin
        end
      endcase
    end
  end

  // turn down at period
  // the match only sets the direction: both counters still step up once more,
  // and that top state belongs to the period
  assign turn_down = ~down_r & match[cpwm_pkg::ADC_A_PERIOD];
  assign turn_up = down_r & (cnt_b_r == cpwm_pkg::CNT_ZERO);
  // counters accept software writes only while stopped
  assign cnt_a_wr = wr & (wb_adr_i == cpwm_pkg::ADR_CNT_A);
  assign cnt_b_wr = wr & (wb_adr_i == cpwm_pkg::ADR_CNT_B);

  // counter pair and direction
  always_comb begin
    cnt_a_nxt = cnt_a_r;
    cnt_b_nxt = cnt_b_r;
    down_nxt = down_r;
    period_lat_nxt = period_lat_r;
    unf_req_nxt = 1'b0;
    cmp_req_nxt = 1'b0;
    adc_nxt = 1'b0;
    if (!running) begin
      period_lat_nxt = period_r;
      down_nxt = 1'b0;
      // dead time loaded into counter a while stopped
      if (cnt_a_wr) begin
        cnt_a_nxt = merge16(cnt_a_r);
      end
      if (cnt_b_wr) begin
        cnt_b_nxt = merge16(cnt_b_r);
      end
    end else if (tick) begin
      cmp_req_nxt = |match;
      adc_nxt = |(match & adc_sel_r);
      if (down_r) begin
        cnt_a_nxt = cnt_a_r - 1'b1;
        cnt_b_nxt = cnt_b_r - 1'b1;
      end else begin
        cnt_a_nxt = cnt_a_r + 1'b1;
        cnt_b_nxt = cnt_b_r + 1'b1;
      end
      if (turn_down) begin
        down_nxt = 1'b1;
      end
      if (turn_up) begin
        down_nxt = 1'b0;
        unf_req_nxt = 1'b1;
      end
    end
  end

  // bus answer: ack one cycle after the request, zero for unmapped offsets
  always_comb begin
    ack_nxt = req;
    rdat_nxt = 32'h00000000;
    unique case (wb_adr_i)
      cpwm_pkg::ADR_START: rdat_nxt = {29'h0, start_r};
      cpwm_pkg::ADR_CH0_CTRL: rdat_nxt = {27'h0, ch0_r};
      cpwm_pkg::ADR_CH1_CTRL: rdat_nxt = {27'h0, ch1_r};
      cpwm_pkg::ADR_FUNC: rdat_nxt = {30'h0, func_r};
      cpwm_pkg::ADR_ADC_SEL: rdat_nxt = {28'h0, adc_sel_r};
      cpwm_pkg::ADR_CNT_A: rdat_nxt = {16'h0, cnt_a_r};
      cpwm_pkg::ADR_CNT_B: rdat_nxt = {16'h0, cnt_b_r};
      cpwm_pkg::ADR_PERIOD: rdat_nxt = {16'h0, period_r};
      cpwm_pkg::ADR_DUTY1: rdat_nxt = {16'h0, duty_r[0]};
      cpwm_pkg::ADR_DUTY2: rdat_nxt = {16'h0, duty_r[1]};
      cpwm_pkg::ADR_DUTY3: rdat_nxt = {16'h0, duty_r[2]};
      cpwm_pkg::ADR_STATUS: rdat_nxt = {30'h0, down_r, running};
      default: rdat_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_r <= '0;
      ch0_r <= '0;
      ch1_r <= '0;
      func_r <= '0;
      adc_sel_r <= '0;
      cnt_a_r <= '0;
      cnt_b_r <= '0;
      period_r <= '0;
      period_lat_r <= '0;
      duty_r <= '{default: '0};
      down_r <= 1'b0;
      ack_r <= 1'b0;
      rdat_r <= '0;
      adc_r <= 1'b0;
      cmp_req_r <= 1'b0;
      unf_req_r <= 1'b0;
    end else begin
      start_r <= start_nxt;
      ch0_r <= ch0_nxt;
      ch1_r <= ch1_nxt;
      func_r <= func_nxt;
      adc_sel_r <= adc_sel_nxt;
      cnt_a_r <= cnt_a_nxt;
      cnt_b_r <= cnt_b_nxt;
      period_r <= period_nxt;
      period_lat_r <= period_lat_nxt;
      duty_r <= duty_nxt;
      down_r <= down_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      adc_r <= adc_nxt;
      cmp_req_r <= cmp_req_nxt;
      unf_req_r <= unf_req_nxt;
    end
  end

  for (genvar k = 0; k < cpwm_pkg::PHASES; k++) begin : g_phase
    cpwm_phase #(.CNT_W(CNT_W)) u_phase (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .running_i(running),
      .down_i(down_r),
      .cnt_a_i(cnt_a_r),
      .cnt_b_i(cnt_b_r),
      .duty_i(duty_r[k]),
      .normal_init_i(func_r[cpwm_pkg::NINIT_BIT]),
      .counter_init_i(func_r[cpwm_pkg::CINIT_BIT]),
      .normal_o(phase_normal_o[k]),
      .counter_o(phase_counter_o[k])
    );
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign adc_trigger_o = adc_r;
  assign compare_req_o = cmp_req_r;
  assign underflow_req_o = unf_req_r;
endmodule // cpwm_top

// ---- common/cpwm_pkg.sv ----
// constants and register map of the complementary pwm timer
// What this block does
// - compare matches can start the converter
// - trigger select register routes chosen matches
// - three normal and three counter-phase outputs
// - count source: divided clock or oscillators
// - external count pin, edge chosen by software
// - counter a reaching period starts down count
// - counter b underflow restarts up count
// - period is twice (m+2-p) source cycles
// - dead time is p loaded into counter
// - normal-phase active twice (m-n-p+1) cycles
// - counter-phase active twice (n+1-p) cycles
// - period value from period compare
// - duty values from three phase compares
// - both run bits set starts counting
// - manual stop enable lets zero stop
// - stopped outputs show initial levels
// - period latched when counting starts
// - each phase has two separate pins
// - request on compare match and underflow
package cpwm_pkg;
  localparam int CNT_W = 16;
  localparam int PHASES = 3;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int PRE_W = 5;
  // register byte offsets
  localparam logic [7:0] ADR_START = 8'h00;
  localparam logic [7:0] ADR_CH0_CTRL = 8'h04;
  localparam logic [7:0] ADR_CH1_CTRL = 8'h08;
  localparam logic [7:0] ADR_FUNC = 8'h0c;
  localparam logic [7:0] ADR_ADC_SEL = 8'h10;
  localparam logic [7:0] ADR_CNT_A = 8'h14;
  localparam logic [7:0] ADR_CNT_B = 8'h18;
  localparam logic [7:0] ADR_PERIOD = 8'h1c;
  localparam logic [7:0] ADR_DUTY1 = 8'h20;
  localparam logic [7:0] ADR_DUTY2 = 8'h24;
  localparam logic [7:0] ADR_DUTY3 = 8'h28;
  localparam logic [7:0] ADR_STATUS = 8'h2c;
  // start_control fields
  localparam int RUN0_BIT = 0;
  localparam int RUN1_BIT = 1;
  localparam int MSTOP_BIT = 2;
  // channel control fields
  localparam int SRC_LSB = 0;
  localparam int SRC_W = 3;
  localparam int EDGE_LSB = 3;
  localparam int EDGE_W = 2;
  // function_control fields
  localparam int NINIT_BIT = 0;
  localparam int CINIT_BIT = 1;
  // adc trigger select: one bit per compare source
  localparam int ADC_W = 4;
  localparam int ADC_A_PERIOD = 0;
  localparam int ADC_A_DUTY1 = 1;
  localparam int ADC_B_DUTY2 = 2;
  localparam int ADC_B_DUTY3 = 3;
  // count source codes
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;
  localparam logic [2:0] SRC_FAST = 3'h6;
  localparam logic [2:0] SRC_FAST_DIV = 3'h7;
  localparam logic [4:0] MASK_DIV2 = 5'h01;
  localparam logic [4:0] MASK_DIV4 = 5'h03;
  localparam logic [4:0] MASK_DIV8 = 5'h07;
  localparam logic [4:0] MASK_DIV32 = 5'h1f;
  // external edge codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
endpackage

// ---- logic/cpwm_clk_src.sv ----
// count source selection: prescaler, oscillator and external edge ticks
module cpwm_clk_src (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // selection
  input wire logic [2:0] src_sel_i,
  input wire logic [1:0] edge_sel_i,
  // source inputs
  input wire logic fast_osc_clock_i,
  input wire logic fast_osc_divided_clock_i,
  input wire logic ext_count_clock_pin_i,
  // one-cycle count enable
  output logic tick_o
);
  logic [cpwm_pkg::PRE_W-1:0] pre_r, pre_nxt;
  logic fast_r, fast_nxt;
  logic fdiv_r, fdiv_nxt;
  logic ext_r, ext_nxt;
  logic ext_rise, ext_fall;

  always_comb begin
    pre_nxt = pre_r + 1'b1;
    fast_nxt = fast_osc_clock_i;
    fdiv_nxt = fast_osc_divided_clock_i;
    ext_nxt = ext_count_clock_pin_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= '0;
      fast_r <= 1'b0;
      fdiv_r <= 1'b0;
      ext_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      fast_r <= fast_nxt;
      fdiv_r <= fdiv_nxt;
      ext_r <= ext_nxt;
    end
  end

  assign ext_rise = ext_count_clock_pin_i & ~ext_r;
  assign ext_fall = ~ext_count_clock_pin_i & ext_r;

  always_comb begin
    unique case (src_sel_i)
      cpwm_pkg::SRC_DIV1: tick_o = 1'b1;
      cpwm_pkg::SRC_DIV2: tick_o = (pre_r & cpwm_pkg::MASK_DIV2) == cpwm_pkg::MASK_DIV2;
      cpwm_pkg::SRC_DIV4: tick_o = (pre_r & cpwm_pkg::MASK_DIV4) == cpwm_pkg::MASK_DIV4;
      cpwm_pkg::SRC_DIV8: tick_o = (pre_r & cpwm_pkg::MASK_DIV8) == cpwm_pkg::MASK_DIV8;
      cpwm_pkg::SRC_DIV32: tick_o = (pre_r & cpwm_pkg::MASK_DIV32) == cpwm_pkg::MASK_DIV32;
      cpwm_pkg::SRC_EXT: begin
        if (edge_sel_i == cpwm_pkg::EDGE_RISE) begin
          tick_o = ext_rise;
        end else if (edge_sel_i == cpwm_pkg::EDGE_FALL) begin
          tick_o = ext_fall;
        end else begin
          tick_o = ext_rise | ext_fall;
        end
      end
      cpwm_pkg::SRC_FAST: tick_o = fast_osc_clock_i & ~fast_r;
      cpwm_pkg::SRC_FAST_DIV: tick_o = fast_osc_divided_clock_i & ~fdiv_r;
    endcase
  end
endmodule // cpwm_clk_src

// ---- logic/cpwm_phase.sv ----
// one phase: normal and counter-phase outputs with dead time
module cpwm_phase #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // counter state
  input wire logic running_i,
  input wire logic down_i,
  input wire logic [CNT_W-1:0] cnt_a_i,
  input wire logic [CNT_W-1:0] cnt_b_i,
  input wire logic [CNT_W-1:0] duty_i,
  // levels
  input wire logic normal_init_i,
  input wire logic counter_init_i,
  // pins
  output logic normal_o,
  output logic counter_o
);
  logic normal_r, normal_nxt;
  logic counter_r, counter_nxt;
  logic n_act, c_act;

  if (CNT_W < 2) begin : g_bad_cnt_w
    $error("cpwm_phase: counter width too small");
  end

  // normal-phase width
  // a pin changes one tick after its match: counting up the match value is
  // still on the old side, and counting down it is still on the old side too
  // counter b all ones is the underflow step, which belongs to the low side
  assign n_act = down_i ? (cnt_b_i >= duty_i) :
    ((cnt_b_i > duty_i) && (cnt_b_i != {CNT_W{1'b1}}));
  // dead time gap
  // counter a leads counter b by p, so the two windows are p apart
  assign c_act = down_i ? (cnt_a_i < duty_i) : (cnt_a_i <= duty_i);

  always_comb begin
    if (running_i) begin
      normal_nxt = n_act ? ~normal_init_i : normal_init_i;
      counter_nxt = c_act ? ~counter_init_i : counter_init_i;
    end else begin
      normal_nxt = normal_init_i;
      counter_nxt = counter_init_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      normal_r <= 1'b0;
      counter_r <= 1'b0;
    end else begin
      normal_r <= normal_nxt;
      counter_r <= counter_nxt;
    end
  end

  assign normal_o = normal_r;
  assign counter_o = counter_r;
endmodule // cpwm_phase

// ---- dv/cpwm_chk.sv ----
// port assertions for the complementary pwm timer
module cpwm_chk #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins and events
  input wire logic [2:0] phase_normal_o,
  input wire logic [2:0] phase_counter_o,
  input wire logic adc_trigger_o,
  input wire logic compare_req_o,
  input wire logic underflow_req_o
);
  logic take;
  logic run;
  logic [2:0] run_r;
  logic [2:0] run_nxt;
  logic [1:0] lev_r;
  logic [1:0] lev_nxt;
  logic [2:0] idle_r;
  logic [2:0] idle_nxt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign run = run_r[0] && run_r[1];
  // zeros only stop when the stop enable was already set before the write
  always_comb begin
    run_nxt = run_r;
    lev_nxt = lev_r;
    if (take && wb_adr_i == cpwm_pkg::ADR_START) begin
      run_nxt = {wb_dat_i[2], wb_dat_i[1:0] | (run_r[1:0] & {2{!run_r[2]}})};
    end
    if (take && wb_adr_i == cpwm_pkg::ADR_FUNC) begin
      lev_nxt = wb_dat_i[1:0];
    end
    idle_nxt = idle_r + {2'h0, idle_r != 3'h7};
    if (run || lev_nxt != lev_r) begin
      idle_nxt = 3'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 3'h0;
      lev_r <= 2'h0;
      idle_r <= 3'h0;
    end else begin
      run_r <= run_nxt;
      lev_r <= lev_nxt;
      idle_r <= idle_nxt;
    end
  end
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RD_UNMAP: assert property (wb_ack_o && !wb_we_i && (wb_adr_i > cpwm_pkg::ADR_STATUS
    || wb_adr_i[1:0] != 2'h0) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_DEAD: assert property (run && $past(run) |-> ((phase_normal_o ^ {3{lev_r[0]}})
    & (phase_counter_o ^ {3{lev_r[1]}})) == 3'h0)
    else $error("both pins of a phase active");
  AST_IDLE_LEVEL: assert property (!run && idle_r == 3'h7 |->
    phase_normal_o == {3{lev_r[0]}} && phase_counter_o == {3{lev_r[1]}})
    else $error("stopped pins not at initial level");
  AST_IDLE_QUIET: assert property (!run && idle_r > 3'h3 |->
    !(underflow_req_o || compare_req_o || adc_trigger_o))
    else $error("event while stopped");
  AST_ADC_CMP: assert property (adc_trigger_o |-> compare_req_o)
    else $error("converter start without compare match");
  AST_UF_GAP: assert property ($rose(underflow_req_o) |=> (!underflow_req_o) [*3])
    else $error("underflows too close");
endmodule // cpwm_chk

// ---- dv/cpwm_partner.sv ----
// gate driver and converter model: sums pin levels per period, makes count sources
module cpwm_partner (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins and events
  input wire logic [2:0] normal_i,
  input wire logic [2:0] counter_i,
  input wire logic underflow_i,
  input wire logic adc_i,
  // free running count sources
  output logic fast_o,
  output logic fast_div_o,
  output logic ext_o,
  // last full period
  output logic [15:0] period_o,
  output logic [15:0] adc_o,
  output logic [2:0][15:0] normal_o,
  output logic [2:0][15:0] counter_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] gen_r = 4'h0;
  logic [15:0] per_r;
  logic [15:0] adc_r;
  logic [2:0][15:0] nrm_r;
  logic [2:0][15:0] cnt_r;
  // rising edges every 4, 16 and 8 clocks
  assign fast_o = gen_r[1];
  assign fast_div_o = gen_r[3];
  assign ext_o = gen_r[2];
  // a window closes at each underflow, so each sum spans exactly one period
  always @(posedge clk_i) begin
    gen_r <= rst_i ? 4'h0 : gen_r + 4'h1;
    if (underflow_i) begin
      period_o <= per_r;
      adc_o <= adc_r;
      normal_o <= nrm_r;
      counter_o <= cnt_r;
    end
    per_r <= underflow_i ? 16'h1 : per_r + 16'h1;
    adc_r <= (underflow_i ? 16'h0 : adc_r) + {15'h0, adc_i};
    for (int k = 0; k < 3; k++) begin
      nrm_r[k] <= (underflow_i ? 16'h0 : nrm_r[k]) + {15'h0, normal_i[k]};
      cnt_r[k] <= (underflow_i ? 16'h0 : cnt_r[k]) + {15'h0, counter_i[k]};
    end
  end
endmodule // cpwm_partner

// ---- dv/tb_cpwm_top.sv ----
// testbench of the complementary pwm timer: register tasks and per-period measures
module tb_cpwm_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic fast_w;
  logic fdiv_w;
  logic ext_w;
  logic [2:0] phase_normal_o;
  logic [2:0] phase_counter_o;
  logic adc_trigger_o;
  logic compare_req_o;
  logic underflow_req_o;
  logic [15:0] per_w;
  logic [15:0] adc_w;
  logic [2:0][15:0] nrm_w;
  logic [2:0][15:0] cnt_w;
  int fail_count = 0;
  int num_checks = 0;
  int src_tab[10] = '{0, 1, 2, 3, 4, 5, 5, 5, 6, 7};
  int edg_tab[10] = '{0, 0, 0, 0, 0, 0, 1, 2, 0, 0};
  int fac_tab[10] = '{1, 2, 4, 8, 32, 8, 8, 4, 4, 16};
  always #2.5 clk_i = ~clk_i;
  cpwm_top #(.CNT_W(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fast_osc_clock_i(fast_w), .fast_osc_divided_clock_i(fdiv_w),
    .ext_count_clock_pin_i(ext_w), .phase_normal_o(phase_normal_o),
    .phase_counter_o(phase_counter_o), .adc_trigger_o(adc_trigger_o),
    .compare_req_o(compare_req_o), .underflow_req_o(underflow_req_o));
  cpwm_partner u_far (.clk_i(clk_i), .rst_i(rst_i), .normal_i(phase_normal_o),
    .counter_i(phase_counter_o), .underflow_i(underflow_req_o), .adc_i(adc_trigger_o),
    .fast_o(fast_w), .fast_div_o(fdiv_w), .ext_o(ext_w), .period_o(per_w), .adc_o(adc_w),
    .normal_o(nrm_w), .counter_o(cnt_w));
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until ack is sampled high, released at that same edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      final_report();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_run(output logic [31:0] r);
    logic [31:0] q;
    bus(1'b0, cpwm_pkg::ADR_STATUS, 32'h0, q);
    r = {31'h0, q[0]};
  endtask
  task automatic wait_uf();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (underflow_req_o !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      fail_count++;
      final_report();
    end
  endtask
  // m = 10, p = 2, duties 4 5 6; odd cases use high initial levels
  task automatic run_case(input int i);
    logic [31:0] q;
    logic lv;
    int f;
    f = fac_tab[i];
    lv = i[0];
    wr(cpwm_pkg::ADR_CH0_CTRL, {27'h0, 2'(edg_tab[i]), 3'(src_tab[i])});
    wr(cpwm_pkg::ADR_CH1_CTRL, {27'h0, 2'(edg_tab[i]), 3'(src_tab[i])});
    wr(cpwm_pkg::ADR_FUNC, {30'h0, lv, lv});
    wr(cpwm_pkg::ADR_ADC_SEL, (i == 9) ? 32'h0 : 32'h1 << (i % 4));
    wr(cpwm_pkg::ADR_CNT_A, 32'h2);
    wr(cpwm_pkg::ADR_CNT_B, 32'h0);
    wr(cpwm_pkg::ADR_PERIOD, 32'ha);
    wr(cpwm_pkg::ADR_START, 32'h1);
    rd_run(q);
    chk("one run bit", q, 32'h0);
    wr(cpwm_pkg::ADR_START, 32'h3);
    rd_run(q);
    chk("both run bits", q, 32'h1);
    wait_uf();
    wr(cpwm_pkg::ADR_PERIOD, 32'h10);
    wr(cpwm_pkg::ADR_CNT_A, 32'h7);
    wait_uf();
    // the partner latches its sums at the underflow edge itself
    @(posedge clk_i);
    chk("period", {16'h0, per_w}, 32'(20 * f));
    // every compare value is passed once counting up and once counting down
    chk("adc starts", {16'h0, adc_w}, (i == 9) ? 32'h0 : 32'h2);
    for (int k = 0; k < 3; k++) begin
      chk("normal", {16'h0, nrm_w[k]}, 32'(lv ? 10 * f + 2 * k * f : 10 * f - 2 * k * f));
      chk("counter", {16'h0, cnt_w[k]}, 32'(lv ? 14 * f - 2 * k * f : 6 * f + 2 * k * f));
    end
    // zeros refused until stop enable is set
    wr(cpwm_pkg::ADR_START, 32'h0);
    rd_run(q);
    chk("stop refused", q, 32'h1);
    wr(cpwm_pkg::ADR_START, 32'h4);
    wr(cpwm_pkg::ADR_START, 32'h4);
    rd_run(q);
    chk("stopped", q, 32'h0);
    repeat (4) @(posedge clk_i);
    chk("idle pins", {26'h0, phase_normal_o, phase_counter_o}, {26'h0, {6{lv}}});
  endtask
  initial begin
    logic [31:0] q;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(8'h30, 32'hffff);
    for (int a = 0; a <= 48; a += 4) begin
      bus(1'b0, 8'(a), 32'h0, q);
      chk("reset value", q, 32'h0);
    end
    wr(cpwm_pkg::ADR_DUTY1, 32'h4);
    wr(cpwm_pkg::ADR_DUTY2, 32'h5);
    wr(cpwm_pkg::ADR_DUTY3, 32'h6);
    bus(1'b0, cpwm_pkg::ADR_DUTY3, 32'h0, q);
    chk("duty readback", q, 32'h6);
    for (int i = 0; i < 10; i++) begin
      run_case(i);
    end
    final_report();
  end
endmodule // tb_cpwm_top
bind cpwm_top cpwm_chk #(.CNT_W(CNT_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .phase_normal_o(phase_normal_o), .phase_counter_o(phase_counter_o),
  .adc_trigger_o(adc_trigger_o), .compare_req_o(compare_req_o),
  .underflow_req_o(underflow_req_o));
